// ==== hw/dlc_pkg.sv ====
// dlc_pkg: constants shared by the dual-channel dac load and reset control
// assumes a 20 MHz system clock and 24-bit command frames from a serial link
package dlc_pkg;
   // clock and timing
   localparam int SYS_CLK_PERIOD_NS = 50;                   // clk_sys period
   localparam int POR_TIME_NS = 1000;                       // power-on reset hold time
   localparam int POR_CYCLES = (POR_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int TIED_LOW_TIME_NS = 10000;                 // low this long counts as tied low
   localparam int TIED_LOW_CYCLES = (TIED_LOW_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int CNT_W = 8;                                // width of the timing counters
   // frame layout
   localparam int FRAME_W = 24;                             // bits per command frame
   localparam int BYTE_W = 8;                               // bits per link byte
   localparam int FRAME_BYTES = 3;                          // command, data msb, data lsb
   localparam int CMD_MSB = 23;                             // command code top bit
   localparam int CMD_LSB = 20;                             // command code bottom bit
   localparam int ADDR_A_BIT = 16;                          // channel a address bit
   localparam int ADDR_B_BIT = 19;                          // channel b address bit
   localparam int CODE_W = 12;                              // dac code width
   localparam int CODE_MSB = 15;                            // code top bit in frame
   localparam int CODE_LSB = 4;                             // code bottom bit in frame
   localparam int MASK_W = 4;                               // load mask register width
   localparam int MASK_A_BIT = 0;                           // channel a mask bit
   localparam int MASK_B_BIT = 3;                           // channel b mask bit
   localparam int REF_BIT = 0;                              // reference setup bit
   localparam int NUM_CH = 2;                               // dac channels
   // reset values
   localparam logic [MASK_W-1:0] MASK_RST = 4'h0;           // every channel follows the pin
   localparam logic REF_OFF_RST = 1'b0;                     // reference on
   localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;       // zero scale
   localparam logic [CODE_W-1:0] CODE_MID = 12'h800;        // midscale
   // command codes
   typedef enum logic [3:0] {
      DLC_CMD_WRITE_IN = 4'h1,                              // write input register
      DLC_CMD_UPDATE = 4'h2,                                // copy input to dac register
      DLC_CMD_WRITE_UPD = 4'h3,                             // write input and dac register
      DLC_CMD_MASK = 4'h5,                                  // load mask register
      DLC_CMD_SW_RESET = 4'h6,                              // software reset
      DLC_CMD_REF = 4'h7                                    // reference setup
   } dlc_cmd_t;
endpackage

// ==== hw/dlc_frame_link.sv ====
// dlc_frame_link: gathers link bytes into 24-bit frames on the link clock
// assumes the serial framing logic delivers one pulse per received data byte
`timescale 1ns/10ps
`default_nettype none
module dlc_frame_link
   import dlc_pkg::*;
(
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire logic link_frame_start,
   input wire logic link_byte_valid,
   input wire logic [dlc_pkg::BYTE_W-1:0] link_byte,
   output logic [dlc_pkg::FRAME_W-1:0] frame_word,
   output logic frame_toggle
);
   import dlc_pkg::*;

   logic [FRAME_W-1:0] shift_r;   // bytes gathered so far, first byte ends on top
   logic [1:0] cnt_r;             // bytes gathered in this frame
   logic [FRAME_W-1:0] word_r;    // last whole frame, held for the other domain
   logic tgl_r;                   // flips once per whole frame
   logic [1:0] cnt_base;          // count after an optional frame start
   logic last_byte;               // this byte completes the frame

   // a start pulse restarts the count even when a byte arrives with it
   assign cnt_base = link_frame_start ? 2'h0 : cnt_r;
   assign last_byte = link_byte_valid && (cnt_base == 2'(FRAME_BYTES - 1));

   // command byte first, then data msb, then data lsb
   always_ff @(posedge link_clk) begin
      if (!link_nrst) begin
         shift_r <= 24'h000000;
         cnt_r <= 2'h0;
      end else if (link_byte_valid) begin
         shift_r <= {shift_r[FRAME_W-BYTE_W-1:0], link_byte};
         cnt_r <= last_byte ? 2'h0 : cnt_base + 2'h1;
      end else begin
         cnt_r <= cnt_base;
      end
   end

   // word is written in the same edge as the toggle; the far side samples it only
   // after two of its own flops have seen the toggle, so it is long stable by then
   always_ff @(posedge link_clk) begin
      if (!link_nrst) begin
         word_r <= 24'h000000;
         tgl_r <= 1'b0;
      end else if (last_byte) begin
         word_r <= {shift_r[FRAME_W-BYTE_W-1:0], link_byte};
         tgl_r <= ~tgl_r;
      end
   end

   assign frame_word = word_r;
   assign frame_toggle = tgl_r;
endmodule
`default_nettype wire

// ==== hw/dlc_ctrl.sv ====
// dlc_ctrl: decides when each channel's dac register takes a new code
// assumes frames arrive on link_clk and all pins are asynchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - command 0101 loads mask bits db3 and db0; the middle two store as zero
// - mask bits clear after reset
// - masked channel sees strobe pin as high
// - channel b mask db3, a mask db0
// - 0001 writes input; dac when strobe low
// - 0010 copies input to dac register
// - 0011 writes input and dac together
// - strobe falling edge updates unmasked channels
// - strobe tied low ignores the mask
// - reset pin clears to selected level
// - no updates while reset pin low
// - command 0110 repeats the power-on reset
// - strobe and reset pins ignored during power-on reset
// - power-up code follows reset level select
// - command 0111 sets reference, on after reset
// - frame is command, data msb, data lsb
// - command code sits in db23 to db20
module dlc_ctrl
   import dlc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire logic link_frame_start,
   input wire logic link_byte_valid,
   input wire logic [dlc_pkg::BYTE_W-1:0] link_byte,
   input wire logic load_strobe_pin_n,
   input wire logic reset_pin_n,
   input wire logic reset_level_select,
   output logic [dlc_pkg::CODE_W-1:0] dac_code_a,
   output logic [dlc_pkg::CODE_W-1:0] dac_code_b,
   output logic [dlc_pkg::CODE_W-1:0] input_code_a,
   output logic [dlc_pkg::CODE_W-1:0] input_code_b,
   output logic [dlc_pkg::MASK_W-1:0] load_mask_bits,
   output logic reference_off,
   output logic por_busy
);
   import dlc_pkg::*;

   // pin index into the synchroniser bank
   // pin_raw below is packed in this index order
   localparam int PIN_LD = 0;
   localparam int PIN_RST = 1;
   localparam int PIN_SEL = 2;
   localparam int NUM_PIN = 3;

   // link side frame assembly
   logic [FRAME_W-1:0] link_word;      // frame held in the link domain
   logic link_tgl;                     // flips once per frame

   // only this module runs on link_clk
   dlc_frame_link u_link (
      .link_clk(link_clk),
      .link_nrst(link_nrst),
      .link_frame_start(link_frame_start),
      .link_byte_valid(link_byte_valid),
      .link_byte(link_byte),
      .frame_word(link_word),
      .frame_toggle(link_tgl)
   );

   // frame event crossing
   logic tgl_s1_r;                     // first flop, read only by the second
   logic tgl_s2_r;                     // settled toggle
   logic tgl_s3_r;                     // previous settled toggle
   logic frm_evt;                      // one cycle per new frame
   logic [FRAME_W-1:0] cmd_word_r;     // frame copied into clk_sys
   logic cmd_vld_r;                    // cmd_word_r is fresh this cycle

   // a toggle, not a pulse: a short link pulse could
   // fall between two clk_sys edges
   // toggle passes two flops; the third only serves the edge detect
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
      end else begin
         tgl_s1_r <= link_tgl;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
      end
   end

   // high for exactly one cycle per frame
   assign frm_evt = tgl_s2_r ^ tgl_s3_r;

   // the link word has been stable since before its toggle settled
   // the word is never synchronised bit by bit,
   // which could tear a frame apart
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cmd_word_r <= 24'h000000;
         cmd_vld_r <= 1'b0;
      end else begin
         cmd_word_r <= frm_evt ? link_word : cmd_word_r;
         cmd_vld_r <= frm_evt;
      end
   end

   // pin synchronisers: three flops, level accepted once stages two and three agree
   // glitches under one cycle never reach q_r;
   // the price is three to four cycles of latency
   // stages reset high, the idle level of the strobe and reset pins
   logic [NUM_PIN-1:0] pin_raw;        // raw asynchronous pins
   logic [NUM_PIN-1:0] pin_q;          // accepted pin levels
   assign pin_raw = {reset_level_select, reset_pin_n, load_strobe_pin_n};

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PIN; gp++) begin : g_pin
         logic s1_r;                   // first flop, read only by s2_r
         logic s2_r;                   // second stage
         logic s3_r;                   // third stage
         logic q_r;                    // accepted level, idle high
         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               s1_r <= 1'b1;
               s2_r <= 1'b1;
               s3_r <= 1'b1;
               q_r <= 1'b1;
            end else begin
               s1_r <= pin_raw[gp];
               s2_r <= s1_r;
               s3_r <= s2_r;
               q_r <= (s2_r == s3_r) ? s3_r : q_r;
            end
         end
         assign pin_q[gp] = q_r;
      end
   endgenerate

   // power-on reset sequence; also rerun by the software reset command
   // one counter, so both resets clear alike
   // a reset frame inside a sequence restarts it
   logic [CNT_W-1:0] por_cnt_r;        // cycles left in the reset sequence
   logic por_act;                      // sequence running
   logic sw_rst;                       // software reset command seen
   assign por_act = (por_cnt_r != 8'h00);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         por_cnt_r <= CNT_W'(POR_CYCLES);
      end else if (sw_rst) begin
         por_cnt_r <= CNT_W'(POR_CYCLES);
      end else if (por_act) begin
         por_cnt_r <= por_cnt_r - 8'h01;
      end
   end

   // strobe pin: falling edge and tied-low detection, the edge muted during power-on reset
   // the count stops at the threshold, so a strobe
   // left low never wraps back to a short pulse
   logic ld_prev_r;                    // strobe level of the previous cycle
   logic ld_fall;                      // accepted high-to-low transition
   logic [CNT_W-1:0] low_cnt_r;        // cycles the strobe has stayed low
   logic tied_low;                     // strobe low long enough to count as tied

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ld_prev_r <= 1'b1;
         low_cnt_r <= 8'h00;
      end else begin
         ld_prev_r <= pin_q[PIN_LD];
         if (pin_q[PIN_LD]) begin
            low_cnt_r <= 8'h00;
         end else if (!tied_low) begin
            low_cnt_r <= low_cnt_r + 8'h01;
         end
      end
   end

   // a short low pulse is an ordinary strobe; only a long steady low bypasses masks
   // tied_low serves masked channels, ld_fall the rest
   assign tied_low = (low_cnt_r >= CNT_W'(TIED_LOW_CYCLES));
   assign ld_fall = ld_prev_r && !pin_q[PIN_LD] && !por_act;

   // hardware reset pin, ignored while power-on reset runs
   // the clear code follows the select pin live,
   // even while the reset pin is held low
   logic hw_rst;                       // reset pin accepted low
   logic clr_all;                      // outputs forced to the clear code
   logic [CODE_W-1:0] clr_code;        // zero scale or midscale
   assign hw_rst = !pin_q[PIN_RST] && !por_act;
   assign clr_all = por_act || hw_rst;
   assign clr_code = pin_q[PIN_SEL] ? CODE_MID : CODE_ZERO;

   // command decode; commands are dropped while the reset pin holds the outputs
   // software reset may restart a running sequence;
   // only an accepted reset pin refuses it
   // unknown codes match no compare and do nothing
   logic [3:0] cmd_code;               // command field of the frame
   logic cmd_ok;                       // frame may act this cycle
   logic is_wr;                        // write input register, dac too if strobe seen low
   logic is_upd;                       // copy input to dac register
   logic is_wru;                       // write and update
   logic is_mask;                      // load mask register
   logic is_ref;                       // reference setup
   logic [CODE_W-1:0] frm_code;        // code carried by the frame

   assign cmd_code = cmd_word_r[CMD_MSB:CMD_LSB];
   assign cmd_ok = cmd_vld_r && !clr_all;
   assign is_wr = cmd_ok && (cmd_code == DLC_CMD_WRITE_IN);
   assign is_upd = cmd_ok && (cmd_code == DLC_CMD_UPDATE);
   assign is_wru = cmd_ok && (cmd_code == DLC_CMD_WRITE_UPD);
   assign is_mask = cmd_ok && (cmd_code == DLC_CMD_MASK);
   assign is_ref = cmd_ok && (cmd_code == DLC_CMD_REF);
   assign sw_rst = cmd_vld_r && !hw_rst && (cmd_code == DLC_CMD_SW_RESET);
   assign frm_code = cmd_word_r[CODE_MSB:CODE_LSB];

   // mask and reference setup registers
   logic [MASK_W-1:0] mask_r;          // per channel strobe mask
   logic ref_off_r;                    // internal reference switched off
   logic [MASK_W-1:0] mask_nxt;        // mask as carried by the frame

   // only db3 and db0 are kept; the middle bits store as zero, address ignored
   assign mask_nxt = {cmd_word_r[MASK_B_BIT],
      2'h0,
      cmd_word_r[MASK_A_BIT]};

   // either reset restores both defaults; the reset
   // pin leaves them, as it only clears the codes
   always_ff @(posedge clk_sys) begin
      if (!nrst || sw_rst) begin
         mask_r <= MASK_RST;
         ref_off_r <= REF_OFF_RST;
      end else begin
         mask_r <= is_mask ? mask_nxt : mask_r;
         ref_off_r <= is_ref ? cmd_word_r[REF_BIT] : ref_off_r;
      end
   end

   // per channel input and dac registers
   // dac priority: clear, frame code, input copy, hold
   // so a frame beats a strobe edge in the same cycle
   logic [NUM_CH-1:0][CODE_W-1:0] inp_code;   // input register view
   logic [NUM_CH-1:0][CODE_W-1:0] dac_code;   // dac register view

   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
         logic sel;                    // frame addresses this channel
         logic masked;                 // channel mask bit
         logic seen_low;               // strobe level this channel acts on
         logic take_wr;                // input register takes frame code
         logic take_dac;               // dac register takes frame code
         logic take_inp;               // dac register takes input register
         logic [CODE_W-1:0] inp_r;     // input register
         logic [CODE_W-1:0] dac_r;     // dac register
         logic [CODE_W-1:0] inp_nxt;   // next input register
         logic [CODE_W-1:0] dac_nxt;   // next dac register

         assign sel = cmd_word_r[(gc == 0) ? ADDR_A_BIT : ADDR_B_BIT];
         assign masked = mask_r[(gc == 0) ? MASK_A_BIT : MASK_B_BIT];
         // a masked channel sees the pin high, unless the pin is tied low
         assign seen_low = masked ? tied_low : !pin_q[PIN_LD];
         assign take_wr = (is_wr || is_wru) && sel;
         assign take_dac = (is_wru || (is_wr && seen_low)) && sel;
         // edges on masked channels are dropped; so are edges during a reset
         assign take_inp = (is_upd && sel) || (ld_fall && !masked && !clr_all);
         assign inp_nxt = clr_all ? clr_code : (take_wr ? frm_code : inp_r);
         assign dac_nxt = clr_all ? clr_code :
                          take_dac ? frm_code :
                          take_inp ? inp_r : dac_r;

         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               inp_r <= CODE_ZERO;
               dac_r <= CODE_ZERO;
            end else begin
               inp_r <= inp_nxt;
               dac_r <= dac_nxt;
            end
         end

         assign inp_code[gc] = inp_r;
         assign dac_code[gc] = dac_r;
      end
   endgenerate

   // status flop for the reset sequence
   // one cycle behind the counter, but from a flop
   logic por_busy_r;                   // mirrors the running sequence
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         por_busy_r <= 1'b1;
      end else begin
         por_busy_r <= por_act;
      end
   end

   // outputs are the registers themselves
   // no logic after a flop, so outputs cannot glitch
   assign dac_code_a = dac_code[0];
   assign dac_code_b = dac_code[1];
   assign input_code_a = inp_code[0];
   assign input_code_b = inp_code[1];
   assign load_mask_bits = mask_r;
   assign reference_off = ref_off_r;
   assign por_busy = por_busy_r;
endmodule
`default_nettype wire

// ==== dv/dlc_ctrl_asserts.sv ====
// dlc_ctrl_asserts: port-level timing checks for the dac load and reset control
// assumes a single clk_sys domain and a bench that holds reset_level_select steady around resets
`timescale 1ns/10ps
`default_nettype none
module dlc_ctrl_asserts
   import dlc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic link_nrst,
   input wire logic link_frame_start,
   input wire logic link_byte_valid,
   input wire logic [dlc_pkg::BYTE_W-1:0] link_byte,
   input wire logic load_strobe_pin_n,
   input wire logic reset_pin_n,
   input wire logic reset_level_select,
   input wire logic [dlc_pkg::CODE_W-1:0] dac_code_a,
   input wire logic [dlc_pkg::CODE_W-1:0] dac_code_b,
   input wire logic [dlc_pkg::CODE_W-1:0] input_code_a,
   input wire logic [dlc_pkg::CODE_W-1:0] input_code_b,
   input wire logic [dlc_pkg::MASK_W-1:0] load_mask_bits,
   input wire logic reference_off,
   input wire logic por_busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // clear code the select pin asks for; sync lag is harmless as the select moves rarely
   wire logic [CODE_W-1:0] clr_code = reset_level_select ? CODE_MID : CODE_ZERO;
   // the two middle mask bits never store anything
   mask_pad_a: assert property (load_mask_bits[2:1] == 2'h0)
      else $error("middle mask bits set");
   // first edge out of reset shows the default mask and reference on
   mask_reset_a: assert property ($rose(nrst) |-> load_mask_bits == MASK_RST && reference_off == REF_OFF_RST)
      else $error("mask or reference not at default after reset");
   // end of a reset sequence leaves both dac codes at the clear code
   por_level_a: assert property ($fell(por_busy) |-> dac_code_a == clr_code && dac_code_b == clr_code)
      else $error("dac code not at clear code after reset sequence");
   por_default_a: assert property ($fell(por_busy) |-> load_mask_bits == MASK_RST && !reference_off)
      else $error("mask or reference not cleared by reset sequence");
   // pin held low well past the synchroniser pins both dacs at the clear code
   pin_clear_a: assert property (
      reset_pin_n == 1'b0 && $past(reset_pin_n, 6) == 1'b0 && !por_busy && $past(por_busy, 8) == 1'b0
      |-> dac_code_a == clr_code && dac_code_b == clr_code) else $error("dac not held at clear code");
   // a strobe fall copies the input register of an unmasked channel within a few cycles
   strobe_update_a: assert property (
      $fell(load_strobe_pin_n) && !load_mask_bits[MASK_A_BIT] && reset_pin_n && !por_busy
      |-> ##[3:7] dac_code_a == input_code_a) else $error("strobe did not update channel a");
   mask_block_a: assert property (
      $fell(load_strobe_pin_n) && load_mask_bits[MASK_B_BIT] && !por_busy |=> $stable(dac_code_b) [*6])
      else $error("masked channel b followed the strobe");
   input_hold_a: assert property ($fell(load_strobe_pin_n) |=> $stable(input_code_a) [*6])
      else $error("strobe changed an input register");
   cover property ($fell(por_busy));
   cover property (reset_pin_n == 1'b0 && !por_busy);
   cover property ($fell(load_strobe_pin_n) && load_mask_bits[MASK_B_BIT]);
endmodule
bind dlc_ctrl dlc_ctrl_asserts u_chk (.clk_sys, .nrst, .link_clk, .link_nrst, .link_frame_start,
   .link_byte_valid, .link_byte, .load_strobe_pin_n, .reset_pin_n, .reset_level_select, .dac_code_a,
   .dac_code_b, .input_code_a, .input_code_b, .load_mask_bits, .reference_off, .por_busy);
`default_nettype wire

// ==== dv/dlc_link_model.sv ====
// dlc_link_model: behaves like the serial master delivering command bytes on the link clock
// assumes the bench calls reset_link once, then send per frame; link clock stops between frames
`timescale 1ns/10ps
`default_nettype none
module dlc_link_model
   import dlc_pkg::*;
(
   output logic link_clk,
   output logic link_nrst,
   output logic link_frame_start,
   output logic link_byte_valid,
   output logic [dlc_pkg::BYTE_W-1:0] link_byte
);
   logic osc = 1'b0; // free 64 ns oscillator, gated onto the link
   logic run = 1'b0; // gate only moves while osc is low, so no runt pulses
   always #32 osc = ~osc;
   assign link_clk = osc & run;
   initial begin
      link_nrst = 1'b0;
      link_frame_start = 1'b0;
      link_byte_valid = 1'b0;
      link_byte = 8'h00;
   end
   // a few link edges in reset, then stop the clock again
   task automatic reset_link;
      @(negedge osc) run = 1'b1;
      repeat (4) @(posedge link_clk);
      #2 link_nrst = 1'b1;
      repeat (2) @(posedge link_clk);
      @(negedge osc) run = 1'b0;
   endtask
   // command byte first, then data msb, then data lsb
   task automatic send(input logic [FRAME_W-1:0] w);
      int i;
      @(negedge osc) run = 1'b1;
      for (i = 0; i < FRAME_BYTES; i++) begin
         link_frame_start = (i == 0);
         link_byte_valid = 1'b1;
         link_byte = w[FRAME_W-1-BYTE_W*i -: BYTE_W];
         @(posedge link_clk);
         #2;
      end
      link_frame_start = 1'b0;
      link_byte_valid = 1'b0;
      link_byte = ~link_byte; // released byte lane shows no stale data
      repeat (3) @(posedge link_clk);
      @(negedge osc) run = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// testbench: drives frames, strobe and reset pins of dlc_ctrl and compares register outputs
// assumes dlc_link_model stands in for the serial master and the checker is bound alongside
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import dlc_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic load_strobe_pin_n = 1'b1; // strobe idles high
   logic reset_pin_n = 1'b1;
   logic reset_level_select = 1'b0; // zero scale first
   wire logic link_clk, link_nrst, link_frame_start, link_byte_valid;
   wire logic [BYTE_W-1:0] link_byte;
   logic [CODE_W-1:0] dac_code_a, dac_code_b, input_code_a, input_code_b;
   logic [MASK_W-1:0] load_mask_bits;
   logic reference_off, por_busy;
   int errors = 0;
   int n_tests = 0;
   always #25 clk_sys = ~clk_sys;
   dlc_link_model u_dlc_link_model (.link_clk(link_clk), .link_nrst(link_nrst),
      .link_frame_start(link_frame_start), .link_byte_valid(link_byte_valid), .link_byte(link_byte));
   dlc_ctrl u_dlc_ctrl (.clk_sys(clk_sys), .nrst(nrst), .link_clk(link_clk), .link_nrst(link_nrst),
      .link_frame_start(link_frame_start), .link_byte_valid(link_byte_valid), .link_byte(link_byte),
      .load_strobe_pin_n(load_strobe_pin_n), .reset_pin_n(reset_pin_n),
      .reset_level_select(reset_level_select), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
      .input_code_a(input_code_a), .input_code_b(input_code_b), .load_mask_bits(load_mask_bits),
      .reference_off(reference_off), .por_busy(por_busy));
   // all stimulus lands 2 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [CODE_W-1:0] exp, input logic [CODE_W-1:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk4(input logic [11:0] ia, input logic [11:0] ib, input logic [11:0] da, input logic [11:0] db);
      cmp("input_code_a", ia, input_code_a);
      cmp("input_code_b", ib, input_code_b);
      cmp("dac_code_a", da, dac_code_a);
      cmp("dac_code_b", db, dac_code_b);
   endtask
   // one frame, then enough cycles for the crossing and register update
   task automatic frm(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] dat);
      u_dlc_link_model.send({cmd, addr, dat});
      tick(10);
   endtask
   task automatic pulse;
      load_strobe_pin_n = 1'b0;
      tick(4);
      load_strobe_pin_n = 1'b1;
      tick(8);
   endtask
   // bounded wait for the reset sequence to finish
   task automatic wait_por;
      int i;
      for (i = 0; i < 60 && por_busy !== 1'b0; i++) tick(1);
      if (por_busy !== 1'b0) begin
         errors++;
         give_verdict();
      end else begin
         tick(2);
      end
   endtask
   initial begin
      fork
         u_dlc_link_model.reset_link();
         tick(20);
      join
      nrst = 1'b1;
      wait_por();
      chk4(12'h000, 12'h000, 12'h000, 12'h000);
      cmp("load_mask_bits", 12'h000, {8'h00, load_mask_bits});
      cmp("reference_off", 12'h000, {11'h000, reference_off});
      frm(4'h1, 4'h1, 16'h1230);
      chk4(12'h123, 12'h000, 12'h000, 12'h000);
      pulse();
      chk4(12'h123, 12'h000, 12'h123, 12'h000);
      frm(4'h3, 4'h8, 16'hABC0);
      chk4(12'h123, 12'hABC, 12'h123, 12'hABC);
      frm(4'h1, 4'h9, 16'h4560);
      chk4(12'h456, 12'h456, 12'h123, 12'hABC);
      frm(4'h5, 4'h6, 16'h000F);
      cmp("load_mask_bits", 12'h009, {8'h00, load_mask_bits});
      pulse();
      chk4(12'h456, 12'h456, 12'h123, 12'hABC);
      frm(4'h2, 4'h1, 16'hFFF0);
      chk4(12'h456, 12'h456, 12'h456, 12'hABC);
      frm(4'h5, 4'h0, 16'h0001);
      frm(4'h1, 4'h9, 16'h7770);
      pulse();
      chk4(12'h777, 12'h777, 12'h456, 12'h777);
      frm(4'h7, 4'h0, 16'h0001);
      cmp("reference_off", 12'h001, {11'h000, reference_off});
      frm(4'h7, 4'hF, 16'hFFFE);
      cmp("reference_off", 12'h000, {11'h000, reference_off});
      // strobe held low: masked a waits, unmasked b follows writes at once
      load_strobe_pin_n = 1'b0;
      tick(8);
      frm(4'h1, 4'h9, 16'h5550);
      chk4(12'h555, 12'h555, 12'h456, 12'h555);
      tick(TIED_LOW_CYCLES);
      frm(4'h1, 4'h1, 16'h3210);
      cmp("dac_code_a", 12'h321, dac_code_a);
      load_strobe_pin_n = 1'b1;
      reset_level_select = 1'b1;
      tick(8);
      reset_pin_n = 1'b0;
      tick(10);
      chk4(12'h800, 12'h800, 12'h800, 12'h800);
      frm(4'h3, 4'h9, 16'h1110);
      chk4(12'h800, 12'h800, 12'h800, 12'h800);
      reset_pin_n = 1'b1;
      tick(10);
      chk4(12'h800, 12'h800, 12'h800, 12'h800);
      frm(4'h5, 4'h0, 16'h0009);
      frm(4'h7, 4'h0, 16'h0001);
      frm(4'h6, 4'h0, 16'h0000);
      wait_por();
      cmp("load_mask_bits", 12'h000, {8'h00, load_mask_bits});
      cmp("reference_off", 12'h000, {11'h000, reference_off});
      chk4(12'h800, 12'h800, 12'h800, 12'h800);
      give_verdict();
   end
endmodule
`default_nettype wire
